//--- design/lst_defines.svh
// constants for the light sensor enable and timing core
// Behaviour
// - wait enable inserts wait between measurements
// - measure enable starts and stops measurement
// - power bit runs oscillator and both converters
// - integration down counter ends at zero
// - integration lasts setting plus one ticks
// - oscillator divided by eleven gives integration clock
// - one tick is 2048 integration clocks
// - wait down counter gives setting plus one ticks
// - wait extend stretches each wait tick twelvefold
// - cycles repeat while power and measure set
// - sleep at reset, idle when powered
// - wait extend is configuration zero bit two
`ifndef LST_DEFINES_SVH
`define LST_DEFINES_SVH

`define LST_ADDR_FUNC_EN 8'h80
`define LST_ADDR_INT_TIME 8'h81
`define LST_ADDR_WAIT_TIME 8'h83
`define LST_ADDR_CFG0 8'h8d

`define LST_RST_FUNC_EN 8'h00
`define LST_RST_INT_TIME 8'h00
`define LST_RST_WAIT_TIME 8'h00
`define LST_RST_CFG0 8'h80

`define LST_BIT_POWER_ON 0
`define LST_BIT_MEASURE_EN 1
`define LST_BIT_WAIT_EN 3
`define LST_BIT_WAIT_EXT 2

`define LST_REF_CLK_KHZ 250000
`define LST_OSC_KHZ 8000
`define LST_OSC_DIV 11
`define LST_INT_CLKS_PER_TICK 2048
`define LST_WAIT_EXT_FACTOR 12
`define LST_FS_PER_TICK 1024
`define LST_FS_SAT_TICKS 64

`endif

//--- design/lst_pkg.sv
// types shared by the light sensor timing core
package lst_pkg;

    typedef enum logic [3:0] {
        LST_SLEEP = 4'b0001,
        LST_IDLE = 4'b0010,
        LST_INTEG = 4'b0100,
        LST_WAIT = 4'b1000
    } lst_state_e;

    typedef struct packed {
        logic osc_on;
        logic adc_on;
        logic integrating;
        logic waiting;
        logic meas_done;
        logic [15:0] full_scale;
    } lst_status_s;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } lst_regreq_s;

endpackage

//--- design/lst_tick_gen.sv
// oscillator emulation and timer tick prescaler
`timescale 1ns/1ps
`include "lst_defines.svh"
module lst_tick_gen
    import lst_pkg::*;
#(
    parameter int unsigned TICK_INT_CLKS = `LST_INT_CLKS_PER_TICK
) (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic run,
    input wire logic restart,
    output logic tick
);
    localparam logic [8:0] OSC_STEP = 9'(`LST_OSC_KHZ / 1000);
    localparam logic [8:0] OSC_WRAP = 9'(`LST_REF_CLK_KHZ / 1000);
    localparam logic [3:0] DIV_LAST = 4'(`LST_OSC_DIV - 1);
    localparam int TW = $clog2(TICK_INT_CLKS + 1);
    localparam logic [TW-1:0] TICK_LAST = TW'(TICK_INT_CLKS - 1);

    // fractional accumulator: 250/8 is not whole, so the average rate is kept exact
    logic [8:0] acc;
    logic [3:0] div_cnt;
    logic [TW-1:0] tick_cnt;
    wire logic [8:0] acc_sum = acc + OSC_STEP;
    wire logic osc_en = run && (acc_sum >= OSC_WRAP);
    wire logic int_en = osc_en && (div_cnt == DIV_LAST);
    wire logic tick_hit = int_en && (tick_cnt == TICK_LAST);

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            acc <= 9'h000;
            div_cnt <= 4'h0;
            tick_cnt <= '0;
            tick <= 1'b0;
        end else if (!run || restart) begin
            acc <= 9'h000;
            div_cnt <= 4'h0;
            tick_cnt <= '0;
            tick <= 1'b0;
        end else begin
            acc <= osc_en ? acc_sum - OSC_WRAP : acc_sum;
            if (osc_en) begin
                div_cnt <= int_en ? 4'h0 : div_cnt + 4'h1;
            end
            if (int_en) begin
                tick_cnt <= tick_hit ? '0 : tick_cnt + TW'(1);
            end
            tick <= tick_hit;
        end
    end
endmodule

//--- design/lst_core.sv
// enable, integration and wait timing core of the light sensor
`timescale 1ns/1ps
`include "lst_defines.svh"
module lst_core
    import lst_pkg::*;
#(
    parameter int unsigned TICK_INT_CLKS = `LST_INT_CLKS_PER_TICK
) (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire lst_regreq_s reg_req,
    output logic [7:0] reg_rdata,
    output lst_status_s status,
    output lst_state_e state
);
    logic [7:0] function_enable;
    logic [7:0] integration_time;
    logic [7:0] wait_time;
    logic [7:0] cfg0;
    logic [7:0] timer;
    logic [3:0] ext_cnt;
    logic meas_done;
    logic [15:0] full_scale;
    logic tick;
    lst_state_e next_state;

    function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] target);
        addr_hit = (a == target);
    endfunction

    // the state test is used only by the two phase decoders, which feed the timer and the status outputs
    function automatic logic is_state(input lst_state_e s, input lst_state_e want);
        is_state = (s == want);
    endfunction

    wire logic wr_en = reg_req.wr && addr_hit(reg_req.addr, `LST_ADDR_FUNC_EN);
    wire logic wr_it = reg_req.wr && addr_hit(reg_req.addr, `LST_ADDR_INT_TIME);
    wire logic wr_wt = reg_req.wr && addr_hit(reg_req.addr, `LST_ADDR_WAIT_TIME);
    wire logic wr_c0 = reg_req.wr && addr_hit(reg_req.addr, `LST_ADDR_CFG0);

    wire logic power_on_bit = function_enable[`LST_BIT_POWER_ON];
    wire logic light_measure_enable = function_enable[`LST_BIT_MEASURE_EN];
    wire logic wait_enable = function_enable[`LST_BIT_WAIT_EN];
    wire logic wait_extend_x12 = cfg0[`LST_BIT_WAIT_EXT];
    wire logic [7:0] integration_time_setting = integration_time;
    wire logic [7:0] wait_time_setting = wait_time;

    localparam logic [3:0] EXT_LAST = 4'(`LST_WAIT_EXT_FACTOR - 1);
    // a wait step completes every tick, or every twelfth tick when stretched
    wire logic wait_step = tick && (!wait_extend_x12 || ext_cnt == EXT_LAST);
    // phase decodes read by the timer, the end detectors and the status outputs
    wire logic in_integ = is_state(state, LST_INTEG);
    wire logic in_wait = is_state(state, LST_WAIT);
    wire logic timer_zero = (timer == 8'h00);
    wire logic integ_end = in_integ && tick && timer_zero;
    wire logic wait_end = in_wait && wait_step && timer_zero;
    wire logic running = power_on_bit && light_measure_enable;
    wire logic enter_integ = (next_state == LST_INTEG) && (state != LST_INTEG || integ_end);
    wire logic enter_wait = (next_state == LST_WAIT) && (state != LST_WAIT);

    // full scale = (setting + 1) * 1024 - 1, pinned at 16 bits from 64 ticks up
    wire logic [8:0] int_ticks = {1'b0, integration_time_setting} + 9'h001;
    wire logic [18:0] fs_raw = {int_ticks, 10'h000} - 19'h00001;
    wire logic [15:0] fs_calc = (int_ticks >= 9'(`LST_FS_SAT_TICKS)) ? 16'hffff
        : fs_raw[15:0];

    always_comb begin
        next_state = state;
        unique case (state)
            LST_SLEEP: begin
                if (power_on_bit) begin
                    next_state = LST_IDLE;
                end
            end
            LST_IDLE: begin
                if (!power_on_bit) begin
                    next_state = LST_SLEEP;
                end else if (light_measure_enable) begin
                    next_state = LST_INTEG;
                end
            end
            LST_INTEG: begin
                if (!power_on_bit) begin
                    next_state = LST_SLEEP;
                end else if (!light_measure_enable) begin
                    next_state = LST_IDLE;
                end else if (integ_end) begin
                    next_state = wait_enable ? LST_WAIT : LST_INTEG;
                end
            end
            LST_WAIT: begin
                if (!power_on_bit) begin
                    next_state = LST_SLEEP;
                end else if (!light_measure_enable) begin
                    next_state = LST_IDLE;
                end else if (wait_end) begin
                    next_state = LST_INTEG;
                end
            end
            default: begin
                next_state = LST_SLEEP;
            end
        endcase
    end

    // held cleared while powered down and restarted on each phase entry, so phases run whole ticks
    lst_tick_gen #(
        .TICK_INT_CLKS(TICK_INT_CLKS)
    ) u_tick (
        .ref_clk(ref_clk),
        .arst_n(arst_n),
        .run(power_on_bit),
        .restart(enter_integ || enter_wait),
        .tick(tick)
    );

    // the host is trusted to set power and measure together and to program
    // the timing first; a late timing write only takes effect at the next reload
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            function_enable <= `LST_RST_FUNC_EN;
        end else if (wr_en) begin
            function_enable <= reg_req.wdata;
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            integration_time <= `LST_RST_INT_TIME;
        end else if (wr_it) begin
            integration_time <= reg_req.wdata;
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            wait_time <= `LST_RST_WAIT_TIME;
        end else if (wr_wt) begin
            wait_time <= reg_req.wdata;
        end
    end

    // reserved bits are kept as written so a read returns what was stored
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            cfg0 <= `LST_RST_CFG0;
        end else if (wr_c0) begin
            cfg0 <= reg_req.wdata;
        end
    end

    // read data is registered and holds until the next read strobe
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            reg_rdata <= 8'h00;
        end else if (reg_req.rd) begin
            unique case (1'b1)
                addr_hit(reg_req.addr, `LST_ADDR_FUNC_EN): reg_rdata <= function_enable;
                addr_hit(reg_req.addr, `LST_ADDR_INT_TIME): reg_rdata <= integration_time;
                addr_hit(reg_req.addr, `LST_ADDR_WAIT_TIME): reg_rdata <= wait_time;
                addr_hit(reg_req.addr, `LST_ADDR_CFG0): reg_rdata <= cfg0;
                default: reg_rdata <= 8'h00;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            state <= LST_SLEEP;
        end else begin
            state <= next_state;
        end
    end

    // one down counter serves both phases since they never overlap
    wire logic timer_step = in_integ ? tick : (in_wait && wait_step);
    wire logic [7:0] next_timer = enter_integ ? integration_time_setting
        : enter_wait ? wait_time_setting
        : (timer_step && !timer_zero) ? timer - 8'h01
        : timer;
    // the stretch count clears on each phase entry and otherwise only moves on ticks inside a wait
    wire logic [3:0] next_ext_cnt = (enter_integ || enter_wait) ? 4'h0
        : (in_wait && wait_step) ? 4'h0
        : (in_wait && tick) ? ext_cnt + 4'h1
        : ext_cnt;

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            timer <= 8'h00;
            ext_cnt <= 4'h0;
        end else begin
            timer <= next_timer;
            ext_cnt <= next_ext_cnt;
        end
    end

    // no done pulse when the same clock stops the cycle
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            meas_done <= 1'b0;
        end else begin
            meas_done <= integ_end && running;
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            full_scale <= 16'h0000;
        end else begin
            full_scale <= fs_calc;
        end
    end

    always_comb begin
        status.osc_on = power_on_bit;
        status.adc_on = power_on_bit;
        status.integrating = in_integ;
        status.waiting = in_wait;
        status.meas_done = meas_done;
        status.full_scale = full_scale;
    end
endmodule

//--- dv/lst_monitor.sv
// assertion checker for the light sensor timing core
`timescale 1ns/1ps
module lst_monitor
    import lst_pkg::*;
#(
    parameter int unsigned TICK_INT_CLKS = 4
) (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire lst_regreq_s reg_req,
    input wire logic [7:0] reg_rdata,
    input wire lst_status_s status,
    input wire lst_state_e state
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!arst_n);
    logic [3:0] en;
    logic [15:0] fs_e;
    logic [15:0] fs_d;
    logic [15:0] dwell;
    lst_state_e ps;
    logic up;
    wire w80 = reg_req.wr && reg_req.addr == 8'h80;
    wire [8:0] at1 = {1'b0, reg_req.wdata} + 9'h001;
    // saturates once integration spans 64 ticks or more
    wire [15:0] fs_w = at1 > 9'h03f ? 16'hffff : {at1[5:0], 10'h000} - 16'h0001;
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            en <= 4'h0;
            fs_e <= 16'h03ff;
            fs_d <= 16'h03ff;
            dwell <= 16'h0000;
            ps <= LST_SLEEP;
            up <= 1'b0;
        end else begin
            en <= w80 ? reg_req.wdata[3:0] : en;
            fs_e <= reg_req.wr && reg_req.addr == 8'h81 ? fs_w : fs_e;
            fs_d <= fs_e;
            dwell <= state == ps ? dwell + 16'h0001 : 16'h0000;
            ps <= state;
            up <= 1'b1;
        end
    end
    a_power_follow: assert property (w80 |=> status.osc_on == $past(reg_req.wdata[0])
        && status.adc_on == status.osc_on) else $error("power flags wrong");
    a_off_sleep: assert property (w80 && !reg_req.wdata[0] |-> ##2 state == LST_SLEEP)
        else $error("not asleep");
    a_measure_stop: assert property (w80 && reg_req.wdata[1:0] == 2'b01
        |-> ##2 state == LST_IDLE) else $error("not idle");
    a_wait_gate: assert property ($rose(status.waiting) |-> en[3] && state == LST_WAIT)
        else $error("wait while disabled");
    a_done_pulse: assert property (status.meas_done |-> $past(state, 2) == LST_INTEG
        ##1 !status.meas_done) else $error("bad done pulse");
    a_repeat_cycle: assert property (status.meas_done && en[1:0] == 2'b11 && !en[3]
        |-> state == LST_INTEG) else $error("cycle not repeated");
    a_full_scale: assert property (up |-> status.full_scale == fs_d)
        else $error("full scale wrong");
    // floor allows for the fractional oscillator accumulator
    a_tick_floor: assert property (ps == LST_INTEG && state == LST_WAIT
        |-> int'(dwell) >= TICK_INT_CLKS * 330) else $error("integration too short");
    a_enable_readback: assert property (reg_req.rd && reg_req.addr == 8'h80
        |=> reg_rdata[3:0] == $past(en)) else $error("enable readback wrong");
endmodule
bind lst_core lst_monitor #(.TICK_INT_CLKS(TICK_INT_CLKS)) u_lst_monitor (.ref_clk(ref_clk),
    .arst_n(arst_n), .reg_req(reg_req), .reg_rdata(reg_rdata), .status(status), .state(state));

//--- dv/lst_host.sv
// host register master model for the light sensor timing core
`timescale 1ns/1ps
module lst_host
    import lst_pkg::*;
(
    input wire logic ref_clk,
    input wire logic [7:0] reg_rdata,
    output lst_regreq_s reg_req
);
    initial reg_req = '0;
    // whole bytes only, so power and measure bits always land together
    task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
        output logic [7:0] q);
        @(posedge ref_clk);
        #1;
        reg_req = '{wr: w, rd: !w, addr: a, wdata: d};
        @(posedge ref_clk);
        #1;
        // released lines flip so stale values are never mistaken for live ones
        reg_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
        q = reg_rdata;
    endtask
endmodule

//--- dv/tb_top.sv
// self-checking bench for the light sensor timing core
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin num_errors++; \
    $display("mismatch %s expected %0h seen %0h", nm, e, g); end end
module tb_top
    import lst_pkg::*;
;
    localparam int TK = 4;
    // one tick in ref_clk cycles: 8 oscillator pulses per 250 cycles
    localparam int TCY = TK * 11 * 125 / 4;
    logic ref_clk;
    logic arst_n;
    logic [7:0] q;
    lst_regreq_s reg_req;
    logic [7:0] reg_rdata;
    lst_status_s status;
    lst_state_e state;
    int num_errors = 0;
    int n_checks = 0;
    int cyc = 0;
    int n;
    lst_core #(.TICK_INT_CLKS(TK)) u_lst_core (.ref_clk(ref_clk), .arst_n(arst_n),
        .reg_req(reg_req), .reg_rdata(reg_rdata), .status(status), .state(state));
    lst_host u_lst_host (.ref_clk(ref_clk), .reg_rdata(reg_rdata), .reg_req(reg_req));
    task automatic tk();
        @(posedge ref_clk);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        u_lst_host.xfer(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        u_lst_host.xfer(1'b0, a, 8'h00, q);
        `CHK("reg_rdata", e, q)
    endtask
    // skip any current stay in st, wait for the next one, count its cycles
    task automatic span(input lst_state_e st);
        for (int i = 0; i < 3; i++) begin
            n = 0;
            while ((state === st) != (i == 1) && n < 20000) begin
                tk();
                n++;
            end
        end
    endtask
    function automatic bit near(input int v, input int e);
        return v >= e - 16 && v <= e + 16;
    endfunction
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 60000) begin
            num_errors++;
            close_out();
        end
    end
    initial begin
        arst_n = 1'b0;
        repeat (10) @(posedge ref_clk);
        #1;
        arst_n = 1'b1;
        rd(8'h80, 8'h00);
        rd(8'h81, 8'h00);
        rd(8'h83, 8'h00);
        rd(8'h8d, 8'h80);
        `CHK("full_scale", 16'h03ff, status.full_scale)
        `CHK("state", LST_SLEEP, state)
        `CHK("osc_on", 1'b0, status.osc_on)
        $display("test reset done");
        wr(8'h81, 8'h3e);
        rd(8'h81, 8'h3e);
        `CHK("full_scale", 16'hfbff, status.full_scale)
        wr(8'h81, 8'h3f);
        wr(8'h83, 8'ha5);
        rd(8'h83, 8'ha5);
        `CHK("full_scale", 16'hffff, status.full_scale)
        wr(8'h82, 8'h55);
        rd(8'h82, 8'h00);
        rd(8'h83, 8'ha5);
        rd(8'h81, 8'h3f);
        wr(8'h80, 8'hf4);
        rd(8'h80, 8'hf4);
        `CHK("osc_on", 1'b0, status.osc_on)
        `CHK("state", LST_SLEEP, state)
        wr(8'h80, 8'h01);
        tk();
        `CHK("state", LST_IDLE, state)
        `CHK("adc_on", 1'b1, status.adc_on)
        $display("test registers done");
        wr(8'h81, 8'h01);
        wr(8'h83, 8'h00);
        wr(8'h80, 8'h0b);
        span(LST_INTEG);
        `CHK("integ_len", 1'b1, near(n, 2 * TCY))
        `CHK("waiting", 1'b1, status.waiting)
        span(LST_WAIT);
        `CHK("wait_len", 1'b1, near(n, TCY))
        `CHK("tick_len", 1'b1, n >= TK * 11 * 31 && n <= TK * 11 * 32)
        `CHK("state", LST_INTEG, state)
        `CHK("integrating", 1'b1, status.integrating)
        wr(8'h8d, 8'h84);
        rd(8'h8d, 8'h84);
        span(LST_WAIT);
        `CHK("wait_ext_len", 1'b1, near(n, 12 * TCY))
        $display("test timing done");
        wr(8'h80, 8'h03);
        n = 0;
        while (status.meas_done !== 1'b1 && n < 8000) begin
            tk();
            n++;
        end
        `CHK("meas_done", 1'b1, status.meas_done)
        `CHK("state", LST_INTEG, state)
        wr(8'h80, 8'h01);
        tk();
        `CHK("state", LST_IDLE, state)
        `CHK("integrating", 1'b0, status.integrating)
        `CHK("waiting", 1'b0, status.waiting)
        wr(8'h80, 8'h00);
        tk();
        `CHK("state", LST_SLEEP, state)
        `CHK("osc_on", 1'b0, status.osc_on)
        $display("test stop done");
        close_out();
    end
endmodule
